// [verilog/ssr_pkg.sv]
/*
 * ssr_pkg: constants and carrier types for the synchronous master receiver.
 * Assumes a single 50 MHz core clock; bus is classic wishbone, 32-bit data.
 */
package ssr_pkg;

  // register byte addresses (printed offsets are not all multiples of four,
  // so each offset is an index and the byte address is four times it)
  localparam logic [7:0] SSR_IDX_RX_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] SSR_IDX_TX_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] SSR_IDX_BAUD_DIVISOR = 8'h99;
  localparam logic [7:0] SSR_IDX_GLOBAL_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] SSR_IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] SSR_IDX_RX_HOLDING_QUEUE = 8'h1a;
  localparam logic [7:0] SSR_IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
  localparam int SSR_ADDR_LSB = 2;

  // receive status/control fields
  localparam int SSR_RCS_SERIAL_PORT_ENABLE = 7;
  localparam int SSR_RCS_NINE_BIT_RX_SELECT = 6;
  localparam int SSR_RCS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int SSR_RCS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int SSR_RCS_OVERRUN_ERROR = 1;
  localparam int SSR_RCS_RX_NINTH_BIT = 0;
  // transmit status/control fields
  localparam int SSR_TXS_CLOCK_SOURCE_MASTER = 7;
  localparam int SSR_TXS_SYNC_MODE = 4;
  localparam int SSR_TXS_HIGH_SPEED_SELECT = 2;
  // flag/enable/global fields
  localparam int SSR_PF_RX_READY = 5;
  localparam int SSR_GIC_GLOBAL_IRQ_ENABLE = 7;
  localparam int SSR_GIC_PERIPHERAL_IRQ_ENABLE = 6;

  // reset values
  localparam logic [7:0] SSR_RST_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] SSR_RST_TX_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] SSR_RST_BAUD_DIVISOR = 8'h00;
  localparam logic [7:0] SSR_RST_GLOBAL_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] SSR_RST_PERIPHERAL_ENABLES_ONE = 8'h00;
  // writable masks: reserved/status bits read back as stored hardware state
  localparam logic [7:0] SSR_WMASK_RX_STATUS_CONTROL = 8'hf0;
  localparam logic [7:0] SSR_WMASK_TX_STATUS_CONTROL = 8'hf4;

  // divider prescales per baud tick: sync /2 (two ticks make one shift
  // clock period of 4*(d+1)), async low /64, async high /16
  localparam int SSR_BAUD_WIDTH = 8;
  localparam logic [5:0] SSR_PRESCALE_SYNC = 6'h01;
  localparam logic [5:0] SSR_PRESCALE_ASYNC_LOW = 6'h3f;
  localparam logic [5:0] SSR_PRESCALE_ASYNC_HIGH = 6'h0f;

  localparam int SSR_WORD_BITS = 9;
  localparam int SSR_QUEUE_DEPTH = 2;

  // one queued entry: data byte plus ninth bit
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } ssr_entry_s;

  // configuration handed to the baud divider
  typedef struct packed {
    logic sync_mode;
    logic high_speed;
    logic [7:0] divisor;
  } ssr_baud_cfg_s;

  typedef enum logic [1:0] {
    SSR_IDLE,
    SSR_SHIFT,
    SSR_DONE
  } ssr_state_e;

endpackage : ssr_pkg

// [verilog/ssr_baud_timer.sv]
/*
 * ssr_baud_timer: free-running divider giving one-cycle baud enables.
 * Assumes one core clock; restart is a one-cycle pulse from the bus slave.
 */
module ssr_baud_timer
  import ssr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // configuration
  input wire ssr_baud_cfg_s cfg_i,
  input wire logic restart_i,
  // baud enable pulse
  output logic tick_o
);

  logic [5:0] pre_q;
  logic [7:0] cnt_q;
  logic [5:0] pre_top;

  // sync ignores the high-speed select entirely [RULE_23]
  always_comb begin
    if (cfg_i.sync_mode) begin
      pre_top = SSR_PRESCALE_SYNC; // [RULE_01]
    end else if (cfg_i.high_speed) begin
      pre_top = SSR_PRESCALE_ASYNC_HIGH; // [RULE_02]
    end else begin
      pre_top = SSR_PRESCALE_ASYNC_LOW; // [RULE_02]
    end
  end

  // prescaler then 8-bit timer with period divisor+1; a divisor write
  // clears both so the new rate starts at once [RULE_21] [RULE_22]
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q <= 6'h00;
      cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      pre_q <= 6'h00;
      cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (pre_q >= pre_top) begin
        pre_q <= 6'h00;
        if (cnt_q >= cfg_i.divisor) begin
          cnt_q <= 8'h00;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

endmodule : ssr_baud_timer

// [verilog/ssr_receiver.sv]
/*
 * ssr_receiver: synchronous master receive path with wishbone registers.
 * Assumes a synchronous slave drives data valid around the falling edge
 * of the shift clock this block generates; one 50 MHz clock.
 */
// Operation
// RULE_01: sync shift clock is core clock over 4*(divisor+1), divisor 0..255.
// RULE_02: async rate is clock over 64*(d+1), or 16*(d+1) at high speed.
// RULE_03: in sync mode, either receive enable starts reception.
// RULE_04: data pin is sampled on the falling shift clock edge.
// RULE_05: single-receive alone takes exactly one word then stops.
// RULE_06: continuous-receive keeps taking words until software clears it.
// RULE_07: both enables set behaves as continuous reception.
// RULE_08: finished word moves to holding queue if a place is free.
// RULE_09: a move into the queue sets the receive-ready flag.
// RULE_10: ready flag reaches interrupt only with its enable bit set.
// RULE_11: ready flag is read-only and clears when queue is read empty.
// RULE_12: queue holds two words while a third shifts in.
// RULE_13: third word finishing into a full queue sets overrun, is dropped.
// RULE_14: overrun clears only when software clears continuous-receive.
// RULE_15: while overrun is set no word enters the queue.
// RULE_16: ninth bit is queued with its byte; reads expose next one.
// RULE_17: software reads status before holding data to keep ninth bit.
// RULE_18: software programs divisor, mode, enables in the set order.
// RULE_19: software clears continuous-receive to recover from an error.
// RULE_20: interrupt needs global and peripheral enables both set.
// RULE_21: writing the divisor restarts the baud timer at once.
// RULE_22: divisor sets period of a free-running 8-bit timer.
// RULE_23: high-speed select has no effect in sync mode.
// RULE_24: queue reads return words oldest first, each freeing one.
// RULE_25: shift clock runs only while a receive enable is active.
module ssr_receiver
  import ssr_pkg::*;
#(
  parameter int QUEUE_DEPTH = SSR_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // serial link
  input wire logic serial_data_pin_i,
  output logic shift_clk_o,
  // interrupt request to the processor
  output logic irq_o
);

  logic [7:0] rcs_q;
  logic [7:0] txs_q;
  logic [7:0] div_q;
  logic [7:0] gic_q;
  logic [7:0] pie_q;
  logic overrun_q;
  ssr_entry_s queue_q [QUEUE_DEPTH];
  logic [1:0] count_q;
  logic rd_ptr_q;
  logic wr_ptr_q;
  logic [1:0] din_sync_q;
  ssr_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [8:0] shift_q;
  logic [31:0] rdata;
  logic hit;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic baud_tick;
  logic div_write;
  logic push;
  logic pop;
  logic word_done;
  logic single_en;
  logic cont_en;
  logic rx_enabled;
  logic [3:0] word_len;
  ssr_baud_cfg_s baud_cfg;

  assign single_en = rcs_q[SSR_RCS_SINGLE_RECEIVE_ENABLE];
  assign cont_en = rcs_q[SSR_RCS_CONTINUOUS_RECEIVE_ENABLE];
  // either enable, port on, sync master mode [RULE_03] [RULE_25]
  assign rx_enabled = (single_en || cont_en)
      && rcs_q[SSR_RCS_SERIAL_PORT_ENABLE]
      && txs_q[SSR_TXS_SYNC_MODE]
      && txs_q[SSR_TXS_CLOCK_SOURCE_MASTER];
  assign word_len = rcs_q[SSR_RCS_NINE_BIT_RX_SELECT] ? 4'(SSR_WORD_BITS)
      : 4'(SSR_WORD_BITS - 1);

  // bus decode: one-cycle ack for every mapped access, err for unmapped words
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign idx = wb_adr_i[9:SSR_ADDR_LSB];
  always_comb begin
    hit = 1'b1;
    case (idx)
      SSR_IDX_RX_STATUS_CONTROL,
      SSR_IDX_TX_STATUS_CONTROL,
      SSR_IDX_BAUD_DIVISOR,
      SSR_IDX_GLOBAL_INTERRUPT_CONTROL,
      SSR_IDX_PERIPHERAL_FLAGS_ONE,
      SSR_IDX_RX_HOLDING_QUEUE,
      SSR_IDX_PERIPHERAL_ENABLES_ONE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  // only byte lane 0 carries register data
  assign wr_en = access && hit && wb_we_i && wb_sel_i[0];
  assign rd_en = access && hit && !wb_we_i;
  assign div_write = wr_en && (idx == SSR_IDX_BAUD_DIVISOR);
  // a read of the holding queue pops one entry [RULE_24]
  assign pop = rd_en && (idx == SSR_IDX_RX_HOLDING_QUEUE)
      && (count_q != 2'd0);

  assign baud_cfg.sync_mode = txs_q[SSR_TXS_SYNC_MODE];
  assign baud_cfg.high_speed = txs_q[SSR_TXS_HIGH_SPEED_SELECT];
  assign baud_cfg.divisor = div_q;

  ssr_baud_timer u_baud (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .cfg_i(baud_cfg),
    .restart_i(div_write),
    .tick_o(baud_tick)
  );

  // bus answer registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access && hit;
      wb_err_o <= access && !hit;
      wb_dat_o <= rd_en ? rdata : 32'h0000_0000;
    end
  end

  // read mux; status shows the ninth bit of the oldest entry [RULE_16]
  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      SSR_IDX_RX_STATUS_CONTROL: begin
        rdata[7:0] = rcs_q;
        rdata[SSR_RCS_OVERRUN_ERROR] = overrun_q;
        rdata[SSR_RCS_RX_NINTH_BIT] = queue_q[rd_ptr_q].ninth;
      end
      SSR_IDX_TX_STATUS_CONTROL: rdata[7:0] = txs_q;
      SSR_IDX_BAUD_DIVISOR: rdata[7:0] = div_q;
      SSR_IDX_GLOBAL_INTERRUPT_CONTROL: rdata[7:0] = gic_q;
      SSR_IDX_PERIPHERAL_FLAGS_ONE:
        rdata[SSR_PF_RX_READY] = (count_q != 2'd0); // [RULE_09] [RULE_11]
      SSR_IDX_RX_HOLDING_QUEUE: rdata[7:0] = queue_q[rd_ptr_q].data;
      SSR_IDX_PERIPHERAL_ENABLES_ONE: rdata[7:0] = pie_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // software registers; single-receive alone self-clears after one word
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rcs_q <= SSR_RST_RX_STATUS_CONTROL;
      txs_q <= SSR_RST_TX_STATUS_CONTROL;
      div_q <= SSR_RST_BAUD_DIVISOR;
      gic_q <= SSR_RST_GLOBAL_INTERRUPT_CONTROL;
      pie_q <= SSR_RST_PERIPHERAL_ENABLES_ONE;
    end else begin
      if (wr_en) begin
        case (idx)
          SSR_IDX_RX_STATUS_CONTROL:
            rcs_q <= wb_dat_i[7:0] & SSR_WMASK_RX_STATUS_CONTROL;
          SSR_IDX_TX_STATUS_CONTROL:
            txs_q <= (wb_dat_i[7:0] & SSR_WMASK_TX_STATUS_CONTROL)
                | SSR_RST_TX_STATUS_CONTROL;
          SSR_IDX_BAUD_DIVISOR: div_q <= wb_dat_i[7:0];
          SSR_IDX_GLOBAL_INTERRUPT_CONTROL: gic_q <= wb_dat_i[7:0];
          SSR_IDX_PERIPHERAL_ENABLES_ONE: pie_q <= wb_dat_i[7:0];
          default: ;
        endcase
      end
      // hardware clear wins over a same-cycle software write of the bit
      if (word_done && !cont_en) begin
        rcs_q[SSR_RCS_SINGLE_RECEIVE_ENABLE] <= 1'b0; // [RULE_05] [RULE_07]
      end
    end
  end

  // overrun: set beats clear; only a cleared continuous enable clears it
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overrun_q <= 1'b0;
    end else if (word_done && (count_q == 2'(QUEUE_DEPTH))
        && !overrun_q) begin
      overrun_q <= 1'b1; // [RULE_13]
    end else if (!cont_en) begin
      overrun_q <= 1'b0; // [RULE_14] [RULE_19]
    end
  end

  // pin synchroniser; only the second stage feeds the shifter
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      din_sync_q <= 2'b00;
    end else begin
      din_sync_q <= {din_sync_q[0], serial_data_pin_i};
    end
  end

  // shift engine: each baud tick toggles the clock; the falling half
  // samples data [RULE_04]. the clock idles low when disabled [RULE_25]
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= SSR_IDLE;
      shift_clk_o <= 1'b0;
      bit_cnt_q <= 4'd0;
      shift_q <= 9'h000;
    end else begin
      case (state_q)
        SSR_IDLE: begin
          shift_clk_o <= 1'b0;
          bit_cnt_q <= 4'd0;
          if (rx_enabled && baud_tick) begin
            state_q <= SSR_SHIFT; // [RULE_03]
            shift_clk_o <= 1'b1;
          end
        end
        SSR_SHIFT: begin
          if (!rx_enabled) begin
            state_q <= SSR_IDLE;
            shift_clk_o <= 1'b0;
          end else if (baud_tick) begin
            shift_clk_o <= !shift_clk_o;
            if (shift_clk_o) begin
              // lsb first: shift in from the top, align on completion
              shift_q <= {din_sync_q[1], shift_q[8:1]}; // [RULE_04]
              bit_cnt_q <= bit_cnt_q + 4'd1;
              if (bit_cnt_q + 4'd1 == word_len) begin
                state_q <= SSR_DONE;
              end
            end
          end
        end
        SSR_DONE: begin
          // continuous mode goes straight on with the next word [RULE_06]
          state_q <= SSR_IDLE;
          bit_cnt_q <= 4'd0;
        end
        default: state_q <= SSR_IDLE;
      endcase
    end
  end

  assign word_done = (state_q == SSR_DONE);
  // move only with a free place and no pending overrun [RULE_08] [RULE_15]
  assign push = word_done && !overrun_q
      && (count_q != 2'(QUEUE_DEPTH)); // [RULE_12]

  // two-entry queue; arrival order kept by pointers [RULE_12] [RULE_24]
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= 2'd0;
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        queue_q[i] <= '0;
      end
    end else begin
      if (push) begin
        // a nine-bit word sits one place lower after its last shift
        if (word_len == 4'(SSR_WORD_BITS)) begin
          queue_q[wr_ptr_q].data <= shift_q[7:0];
          queue_q[wr_ptr_q].ninth <= shift_q[8];
        end else begin
          queue_q[wr_ptr_q].data <= shift_q[8:1];
          queue_q[wr_ptr_q].ninth <= 1'b0;
        end
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q; // [RULE_16]
      end
      count_q <= count_q + 2'(push) - 2'(pop); // [RULE_11]
    end
  end

  // ready flag gated by its enable, then global and peripheral enables
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (count_q != 2'd0) && pie_q[SSR_PF_RX_READY] // [RULE_10]
          && gic_q[SSR_GIC_GLOBAL_IRQ_ENABLE]
          && gic_q[SSR_GIC_PERIPHERAL_IRQ_ENABLE]; // [RULE_20]
    end
  end

endmodule : ssr_receiver

// [verif/ssr_slave_model.sv]
/*
 * ssr_slave_model: synchronous serial slave feeding the receiver.
 * Assumes the master's shift clock idles low and is sampled on its fall.
 */
module ssr_slave_model
  import ssr_pkg::*;
(
  // reset
  input wire logic reset_n_i,
  // serial link
  input wire logic shift_clk_i,
  output logic serial_data_o,
  // words sent in turn, entry 0 first, lsb first
  input wire ssr_entry_s [3:0] words_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] bit_q;
  logic [1:0] word_q;

  // the rise shows the next bit; after the fall the hold time is over,
  // so the line shows the inverse instead of a stale bit
  always @(shift_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_q <= 4'h0;
      word_q <= 2'h0;
      serial_data_o <= 1'b0;
    end else if (shift_clk_i === 1'b1) begin
      serial_data_o <= words_i[word_q][bit_q];
    end else if (shift_clk_i === 1'b0) begin
      serial_data_o <= ~serial_data_o;
      if (bit_q == 4'(SSR_WORD_BITS - 1)) begin
        bit_q <= 4'h0;
        word_q <= word_q + 2'h1;
      end else begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end
endmodule : ssr_slave_model

// [verif/ssr_receiver_checker.sv]
/*
 * ssr_receiver_checker: port-level assertions for ssr_receiver.
 * Assumes one core clock and a classic wishbone master.
 */
module ssr_receiver_checker
  import ssr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // link and interrupt
  input wire logic shift_clk_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] idx;
  logic [7:0] gic_q, pie_q, rcs_q, txs_q;
  logic req, irq_en, rx_en;
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign irq_en = gic_q[SSR_GIC_GLOBAL_IRQ_ENABLE] & pie_q[SSR_PF_RX_READY]
    & gic_q[SSR_GIC_PERIPHERAL_IRQ_ENABLE];
  assign rx_en = rcs_q[7] & (rcs_q[5] | rcs_q[4]) & txs_q[7] & txs_q[4];

  // shadow of written control bits, taken on the same edge as the design
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gic_q <= 8'h00;
      pie_q <= 8'h00;
      rcs_q <= 8'h00;
      txs_q <= 8'h00;
    end else if (req & wb_we_i & wb_sel_i[0]) begin
      if (idx == SSR_IDX_GLOBAL_INTERRUPT_CONTROL) gic_q <= wb_dat_i[7:0];
      if (idx == SSR_IDX_PERIPHERAL_ENABLES_ONE) pie_q <= wb_dat_i[7:0];
      if (idx == SSR_IDX_RX_STATUS_CONTROL) rcs_q <= wb_dat_i[7:0];
      if (idx == SSR_IDX_TX_STATUS_CONTROL) txs_q <= wb_dat_i[7:0];
    end
  end

  function automatic logic mapped(input logic [7:0] i);
    return i inside {SSR_IDX_RX_STATUS_CONTROL, SSR_IDX_TX_STATUS_CONTROL,
      SSR_IDX_BAUD_DIVISOR, SSR_IDX_GLOBAL_INTERRUPT_CONTROL,
      SSR_IDX_PERIPHERAL_FLAGS_ONE, SSR_IDX_RX_HOLDING_QUEUE,
      SSR_IDX_PERIPHERAL_ENABLES_ONE};
  endfunction : mapped

  sequence s_taken;
    req;
  endsequence
  sequence s_answer;
    ##1 (wb_ack_o ^ wb_err_o);
  endsequence

  a_bus_answer: assert property (s_taken |-> s_answer)
    else $error("request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_both: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_err_unmapped: assert property (req && !mapped(idx) |=> wb_err_o)
    else $error("unmapped access not refused");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_txs_bit_one: assert property (
    req && !wb_we_i && idx == SSR_IDX_TX_STATUS_CONTROL |=> wb_dat_o[1])
    else $error("status bit one reads zero");
  a_irq_gated: assert property (irq_o |-> $past(irq_en))
    else $error("interrupt while masked");
  a_clk_half_min: assert property (
    $changed(shift_clk_o) |=> $stable(shift_clk_o) [*1])
    else $error("shift clock half period too short");
  a_clk_idle: assert property (!rx_en && !shift_clk_o |=> !shift_clk_o)
    else $error("shift clock runs while disabled");
endmodule : ssr_receiver_checker

bind ssr_receiver ssr_receiver_checker ssr_receiver_checker_i (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .shift_clk_o(shift_clk_o),
  .irq_o(irq_o));

// [verif/testbench.sv]
/*
 * testbench: drives ssr_receiver over wishbone with a serial slave model.
 * Assumes a 50 MHz core clock and nine-bit frames throughout.
 */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ssr_pkg::*;
  localparam logic [7:0] RCS = SSR_IDX_RX_STATUS_CONTROL;
  localparam logic [7:0] TXS = SSR_IDX_TX_STATUS_CONTROL;
  localparam logic [7:0] BAUD = SSR_IDX_BAUD_DIVISOR;
  localparam logic [7:0] GIC = SSR_IDX_GLOBAL_INTERRUPT_CONTROL;
  localparam logic [7:0] PF = SSR_IDX_PERIPHERAL_FLAGS_ONE;
  localparam logic [7:0] RX = SSR_IDX_RX_HOLDING_QUEUE;
  localparam logic [7:0] PIE = SSR_IDX_PERIPHERAL_ENABLES_ONE;
  typedef struct packed {
    logic [7:0] ix;
    logic w;
    logic [7:0] d;
    logic [7:0] x;
    logic e;
  } ssr_row_s;
  // reset values, access kinds and refused places
  ssr_row_s rows [15] = '{
    '{RCS, 1'b0, 8'h00, 8'h00, 1'b0}, '{TXS, 1'b0, 8'h00, 8'h02, 1'b0},
    '{BAUD, 1'b0, 8'h00, 8'h00, 1'b0}, '{GIC, 1'b0, 8'h00, 8'h00, 1'b0},
    '{PF, 1'b0, 8'h00, 8'h00, 1'b0}, '{RX, 1'b0, 8'h00, 8'h00, 1'b0},
    '{PIE, 1'b0, 8'h00, 8'h00, 1'b0}, '{TXS, 1'b1, 8'h94, 8'h00, 1'b0},
    '{TXS, 1'b0, 8'h00, 8'h96, 1'b0}, '{BAUD, 1'b1, 8'h5a, 8'h00, 1'b0},
    '{BAUD, 1'b0, 8'h00, 8'h5a, 1'b0}, '{PF, 1'b1, 8'hff, 8'h00, 1'b0},
    '{PF, 1'b0, 8'h00, 8'h00, 1'b0}, '{8'h00, 1'b0, 8'h00, 8'h00, 1'b1},
    '{8'h01, 1'b1, 8'hff, 8'h00, 1'b1}};
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [9:0] wb_adr = 10'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat, rd;
  logic wb_ack, wb_err, sdata, sclk, irq, er;
  ssr_entry_s [3:0] words = {9'h03c, 9'h10f, 9'h096, 9'h1a5};
  int num_errors = 0;
  int checks = 0;
  int n;

  always #10 core_clk_i = ~core_clk_i;

  ssr_receiver ssr_receiver_i (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .wb_err_o(wb_err), .serial_data_pin_i(sdata), .shift_clk_o(sclk),
    .irq_o(irq));
  ssr_slave_model ssr_slave_model_i (.reset_n_i(reset_n_i),
    .shift_clk_i(sclk), .serial_data_o(sdata), .words_i(words));

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic hang;
    num_errors++;
    $display("ERROR %0t wait ran out", $time);
    summarize();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t saw %h wanted %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack or err is sampled
  task automatic wb(input logic [7:0] ix, input logic w, input logic [7:0] d);
    int k;
    @(posedge core_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= {ix, 2'b00};
    wb_sel <= 4'hf;
    wb_wdat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (wb_ack !== 1'b1 && wb_err !== 1'b1 && k < 64);
    if (wb_ack !== 1'b1 && wb_err !== 1'b1) hang();
    rd = wb_rdat;
    er = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic poll(input logic [7:0] ix, input int b, input logic v);
    int k;
    k = 0;
    do begin
      wb(ix, 1'b0, 8'h00);
      k++;
    end while (rd[b] !== v && k < 400);
    if (rd[b] !== v) hang();
  endtask : poll

  // length of one high phase of the shift clock, in core clocks
  task automatic half(output int c);
    int k;
    k = 0;
    c = 0;
    while (sclk === 1'b1 && k < 500) begin
      @(posedge core_clk_i);
      k++;
    end
    while (sclk !== 1'b1 && k < 500) begin
      @(posedge core_clk_i);
      k++;
    end
    while (sclk === 1'b1 && c < 500) begin
      @(posedge core_clk_i);
      c++;
    end
    if (k == 500 || c == 500) hang();
  endtask : half

  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i].ix, rows[i].w, rows[i].d);
      chk({31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) chk(rd, {24'h00_0000, rows[i].x});
    end
    $display("register table done");
    // single word; setup order as software must keep it
    wb(BAUD, 1'b1, 8'h01);
    wb(TXS, 1'b1, 8'h94);
    wb(RCS, 1'b1, 8'hc0);
    wb(PIE, 1'b1, 8'h20);
    wb(GIC, 1'b1, 8'hc0);
    wb(RCS, 1'b1, 8'he0);
    half(n);
    chk(32'(n), 32'h0000_0004);
    poll(PF, 5, 1'b1);
    chk({31'h0, irq}, 32'h0000_0001);
    wb(RCS, 1'b0, 8'h00); // status first keeps the ninth bit
    chk(rd, 32'h0000_00c1);
    wb(RX, 1'b0, 8'h00);
    chk(rd, 32'h0000_00a5);
    repeat (300) @(posedge core_clk_i);
    wb(PF, 1'b0, 8'h00);
    chk(rd, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("single receive done");
    // both enables: continuous until the third word overruns
    wb(RCS, 1'b1, 8'hf0);
    poll(RCS, 1, 1'b1);
    wb(GIC, 1'b1, 8'h40);
    @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(GIC, 1'b1, 8'hc0);
    @(posedge core_clk_i);
    chk({31'h0, irq}, 32'h0000_0001);
    wb(RCS, 1'b0, 8'h00);
    chk(rd, 32'h0000_00f2);
    wb(RX, 1'b0, 8'h00);
    chk(rd, 32'h0000_0096);
    wb(RCS, 1'b0, 8'h00);
    chk(rd, 32'h0000_00f3);
    wb(RX, 1'b0, 8'h00);
    chk(rd, 32'h0000_000f);
    repeat (400) @(posedge core_clk_i);
    wb(PF, 1'b0, 8'h00);
    chk(rd, 32'h0000_0000);
    wb(RCS, 1'b0, 8'h00);
    chk({31'h0, rd[1]}, 32'h0000_0001);
    wb(RCS, 1'b1, 8'hc0); // recovery by clearing continuous
    wb(RCS, 1'b0, 8'h00);
    chk(rd & 32'h0000_00fe, 32'h0000_00c0);
    $display("continuous and overrun done");
    // reset in mid-run returns registers and the link to their idle state
    reset_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    wb(RCS, 1'b0, 8'h00);
    chk(rd, 32'h0000_0000);
    wb(TXS, 1'b0, 8'h00);
    chk(rd, 32'h0000_0002);
    wb(BAUD, 1'b0, 8'h00);
    chk(rd, 32'h0000_0000);
    chk({31'h0, sclk}, 32'h0000_0000);
    $display("mid-run reset done");
    summarize();
  end
endmodule : testbench
